/* File: hdl/drc_pkg.sv */
package drc_pkg;

    // Address geometry
    localparam int ADDR_W     = 14;             // Full word address
    localparam int HALF_W     = 7;              // Row or column half
    localparam int ROWS       = 128;            // Rows needing refresh

    // Clock rate and documented times
    localparam int CLK_MHZ      = 250;          // ref_clk_i rate
    localparam int REF_MS       = 2;            // Refresh period
    localparam int INIT_CYCLES  = 8;            // Wake-up strobe cycles
    localparam int STROBE_NS    = 300;          // Row strobe low time
    localparam int CAS_NS       = 180;          // Column strobe low time
    localparam int PRE_NS       = 180;          // Row strobe precharge
    localparam int RCD_NS       = 80;           // Row to column delay

    // Least times round up to whole cycles
    localparam int RAS_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int CAS_CYC = (CAS_NS * CLK_MHZ + 999) / 1000;
    localparam int PRE_CYC = (PRE_NS * CLK_MHZ + 999) / 1000;
    localparam int RCD_CYC = (RCD_NS * CLK_MHZ + 999) / 1000;
    // Longest interval per row rounds down
    localparam int REF_CYC = (REF_MS * CLK_MHZ * 1000) / ROWS;

    // Request from the user side
    typedef struct packed {
        logic              wr;                  // 1 write, 0 read
        logic [ADDR_W-1:0] addr;                // Word address
        logic              din;                 // Write bit
    } drc_req_t;

    // Pins toward the memory
    typedef struct packed {
        logic              ras_n;               // Row strobe
        logic              cas_n;               // Column strobe
        logic              we_n;                // Write enable
        logic [HALF_W-1:0] muxed_address_inputs; // Shared address pins
        logic              din;                 // Data in pin
    } drc_pins_t;

endpackage : drc_pkg

/* File: hdl/drc_ctrl.sv */
`timescale 1ns/10ps
// Contract
// - 14-bit address sent as two 7-bit halves
// - Row latched on row fall, column on column fall
// - Column low kept through hidden refresh cycles; not done, the column strobe rises at every cycle end
// - All 128 rows visited every 2ms
// - Eight row-strobe cycles after power or idle; done only after reset, not after idle
// - Write enable high throughout a read
// - No cycle ends before minimum pulse widths
module drc_ctrl
#(
    parameter int REF_INTERVAL = drc_pkg::REF_CYC  // Cycles between refreshes
)
(
    input  wire logic              ref_clk_i,      // System clock
    input  wire logic              rst_i,          // Synchronous reset
    input  wire logic              req_valid_i,    // Request offered
    input  wire drc_pkg::drc_req_t req_i,          // Request contents
    output logic                   req_ready_o,    // Request taken
    output logic                   rd_valid_o,     // Read bit valid pulse
    output logic                   rd_data_o,      // Read bit
    output logic                   init_done_o,    // Wake-up cycles done
    output drc_pkg::drc_pins_t     pins_o,         // Memory strobes, address
    input  wire logic              dout_i          // Memory data out pin
);
    import drc_pkg::*;

    // Controller states
    typedef enum logic [2:0] {
        ST_IDLE,                                   // Strobes high, waiting
        ST_ROW,                                    // Row strobe low, row half out
        ST_COL,                                    // Column strobe low, column half out
        ST_HOLD,                                   // Both low until row width met
        ST_PRE                                     // Both high for precharge
    } drc_state_t;

    drc_state_t        state;                      // Current state
    drc_state_t        next_state;                 // Next state
    logic [15:0]       tmr;                        // Phase timer
    logic [15:0]       ref_cnt;                    // Refresh interval timer
    logic              ref_due;                    // Refresh owed
    logic [HALF_W-1:0] ref_row;                    // Refresh row counter
    logic [3:0]        init_cnt;                   // Wake-up cycles issued
    logic              is_ref;                     // Current cycle is refresh
    drc_req_t          cur;                        // Latched request
    logic              dout_s1;                    // Data sync stage 1
    logic              dout_s2;                    // Data sync stage 2
    logic              tmr_done;                   // Phase time met
    logic              take_req;                   // Accept user request
    logic              start_ref;                  // Begin refresh cycle
    logic              next_ras_low;               // Row strobe low next cycle
    logic              next_cas_low;               // Column strobe low next cycle
    logic              next_we_low;                // Write enable low next cycle
    logic [HALF_W-1:0] next_addr;                  // Address half for next cycle

    // Decode of what the idle state starts; refresh first
    assign tmr_done  = (tmr == 16'h0000);
    assign start_ref = (state == ST_IDLE) && (ref_due || !init_done_o);
    assign take_req  = (state == ST_IDLE) && !start_ref && req_valid_i;
    assign req_ready_o = take_req;

    // State sequencing
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE: if (start_ref || take_req) next_state = ST_ROW;
            // Row strobe low; refresh skips the column phase
            ST_ROW:  if (tmr_done) next_state = is_ref ? ST_PRE : ST_COL;
            ST_COL:  if (tmr_done) next_state = ST_HOLD;
            ST_HOLD: if (tmr_done) next_state = ST_PRE;
            ST_PRE:  if (tmr_done) next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // State register and phase timer
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            state <= ST_IDLE;
            tmr   <= 16'h0000;
        end
        else
        begin
            state <= next_state;
            if (next_state != state)
            begin
                // Phase lengths keep the minimum strobe widths
                case (next_state)
                    ST_ROW:  tmr <= 16'(((start_ref ? RAS_CYC : RCD_CYC)) - 1);
                    ST_COL:  tmr <= 16'(CAS_CYC - 1);
                    ST_HOLD: tmr <= 16'(RAS_CYC - RCD_CYC - 1);
                    ST_PRE:  tmr <= 16'(PRE_CYC - 1);
                    default: tmr <= 16'h0000;
                endcase
            end
            else if (!tmr_done)
            begin
                tmr <= tmr - 16'h0001;
            end
        end
    end

    // Request capture and refresh bookkeeping
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            cur      <= '0;
            is_ref   <= 1'b0;
            ref_cnt  <= 16'h0000;
            ref_due  <= 1'b0;
            ref_row  <= 7'h00;
            init_cnt <= 4'h0;
        end
        else
        begin
            if (take_req)
                cur <= req_i;
            if (state == ST_IDLE)
                is_ref <= start_ref;
            // One row owed every REF_INTERVAL cycles; set wins over clear
            if (ref_cnt >= 16'(REF_INTERVAL - 1))
            begin
                ref_cnt <= 16'h0000;
                ref_due <= 1'b1;
            end
            else
            begin
                ref_cnt <= ref_cnt + 16'h0001;
                if (start_ref && init_done_o)
                    ref_due <= 1'b0;
            end
            // Row counter steps after each refresh and wraps
            if (state == ST_PRE && tmr_done && is_ref)
            begin
                ref_row <= ref_row + 7'h01;
                if (!init_done_o)
                    init_cnt <= init_cnt + 4'h1;
            end
        end
    end

    assign init_done_o = (init_cnt >= 4'(INIT_CYCLES));

    // Phases that hold the row strobe low
    function automatic logic row_phase(input drc_state_t st);
        row_phase = (st == ST_ROW) || (st == ST_COL) || (st == ST_HOLD);
    endfunction : row_phase

    // Phases that hold the column strobe low
    function automatic logic col_phase(input drc_state_t st);
        col_phase = (st == ST_COL) || (st == ST_HOLD);
    endfunction : col_phase

    // Row strobe low from the row phase until precharge
    assign next_ras_low = row_phase(next_state);
    // Column strobe only for user cycles; refresh leaves the output off
    assign next_cas_low = col_phase(next_state) && !is_ref;
    // Write enable low only in a user write; a read keeps it high throughout
    assign next_we_low  = next_cas_low && cur.wr;

    // Row half loaded once on leaving idle, column half once on leaving the
    // row phase; otherwise held, so the address never moves while the column strobe is low
    assign next_addr = (state == ST_IDLE && next_state == ST_ROW)
                         ? (start_ref ? ref_row : req_i.addr[HALF_W-1:0])
                     : (state == ST_ROW && next_state == ST_COL)
                         ? cur.addr[ADDR_W-1:HALF_W]
                     : pins_o.muxed_address_inputs;

    // Pin registers; strobe and address changes land on one edge
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            // Strobes high and the bus quiet through reset
            pins_o <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                        muxed_address_inputs: 7'h00, din: 1'b0};
        end
        else
        begin
            pins_o.ras_n                <= !next_ras_low;
            // Column strobe rises at every cycle end; no hidden refresh is run
            pins_o.cas_n                <= !next_cas_low;
            pins_o.we_n                 <= !next_we_low;
            pins_o.muxed_address_inputs <= next_addr;
            // Only the addressed cell takes this bit
            pins_o.din                  <= cur.din;
        end
    end

    // Read data sampled while column strobe low, before release
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            dout_s1    <= 1'b0;
            dout_s2    <= 1'b0;
            rd_valid_o <= 1'b0;
            rd_data_o  <= 1'b0;
        end
        else
        begin
            dout_s1    <= dout_i;
            dout_s2    <= dout_s1;
            rd_valid_o <= 1'b0;
            // One-cycle valid pulse, raised on the edge that releases the column strobe
            if (state == ST_HOLD && tmr_done && !cur.wr && !is_ref)
            begin
                rd_valid_o <= 1'b1;
                rd_data_o  <= dout_s2;
            end
        end
    end

endmodule : drc_ctrl

/* File: tb/drc_dram_model.sv */
`timescale 1ns/10ps
// Behavioural 16K x 1 memory answering the controller's strobes
module drc_dram_model
    import drc_pkg::*;
(
    input  wire drc_pins_t pins_i,   // Strobes, address and data in
    output logic           dout_o    // Data out, shows a flipped bit while released
);
    logic              mem  [2**ADDR_W] = '{default: 1'b0}; // Stored cells
    time               seen [ROWS]      = '{default: 0};    // Last visit of each row
    logic [HALF_W-1:0] row;                                 // Latched row half
    logic              oe   = 1'b0;                         // Output driven
    logic              last = 1'b0;                         // Last bit driven
    int                falls = 0;                           // Row strobe falls seen

    // Row latch; every row strobe refreshes that row
    always @(negedge pins_i.ras_n)
    begin
        // Address moves on the same edge as the strobe; let it settle first
        #0.5;
        row = pins_i.muxed_address_inputs;
        falls++;
        seen[row] = $time;
    end

    // Column latch: read drives the cell, write stores only the addressed cell
    always @(negedge pins_i.cas_n)
    begin
        // Address and write enable change with the strobe, data several cycles earlier; settle first
        #0.5;
        oe = pins_i.we_n;
        if (oe)
            last = mem[{pins_i.muxed_address_inputs, row}];
        else
            mem[{pins_i.muxed_address_inputs, row}] = pins_i.din;
    end

    // Column strobe high releases the output, whatever the row strobe does
    always @(posedge pins_i.cas_n)
        oe = 1'b0;

    // Held bit while driven; inverse of it once released
    assign dout_o = oe ? last : ~last;
endmodule : drc_dram_model

/* File: tb/drc_ctrl_assertions.sv */
`timescale 1ns/10ps
// Port checks on strobe order, widths and request handling
module drc_ctrl_checker
    import drc_pkg::*;
#(
    parameter int REF_INTERVAL = REF_CYC // Cycles between refreshes
)
(
    input wire logic      ref_clk_i,
    input wire logic      rst_i,
    input wire logic      req_valid_i,
    input wire drc_req_t  req_i,
    input wire logic      req_ready_o,
    input wire logic      rd_valid_o,
    input wire logic      rd_data_o,
    input wire logic      init_done_o,
    input wire drc_pins_t pins_o,
    input wire logic      dout_i
);
    int          lowr;      // Cycles row strobe has been low
    int          lowc;      // Cycles column strobe has been low
    int          highr;     // Cycles row strobe has been high
    logic [13:0] taddr;     // Address of the last taken request
    wire         take = req_valid_i && req_ready_o; // Request accepted

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // Strobe low counters and taken address capture
    always_ff @(posedge ref_clk_i)
    begin
        lowr <= (rst_i || pins_o.ras_n) ? 0 : lowr + 1;
        lowc <= (rst_i || pins_o.cas_n) ? 0 : lowc + 1;
        // Reset counts as a full precharge
        highr <= rst_i ? PRE_CYC : (pins_o.ras_n ? highr + 1 : 0);
        taddr <= take ? req_i.addr : taddr;
    end

    a_row_on_take: assert property (take |-> ##[1:2] ($fell(pins_o.ras_n)
        && pins_o.muxed_address_inputs == taddr[6:0])) else $error("row half wrong");
    a_col_on_take: assert property (take |-> ##[2:40] ($fell(pins_o.cas_n)
        && pins_o.muxed_address_inputs == taddr[13:7])) else $error("column half wrong");
    a_ready_idle: assert property (req_ready_o |-> init_done_o && pins_o.ras_n
        && pins_o.cas_n) else $error("ready while busy");
    a_ras_width: assert property ($rose(pins_o.ras_n) |-> lowr >= RAS_CYC)
        else $error("row strobe too short");
    a_cas_width: assert property ($rose(pins_o.cas_n) |-> lowc >= CAS_CYC)
        else $error("column strobe too short");
    a_ras_precharge: assert property ($fell(pins_o.ras_n) |-> highr >= PRE_CYC)
        else $error("precharge cut short");
    a_we_steady: assert property (!pins_o.cas_n && $past(!pins_o.cas_n)
        |-> $stable(pins_o.we_n)) else $error("write enable moved");
    a_cas_in_ras: assert property (!pins_o.cas_n |-> !pins_o.ras_n)
        else $error("column strobe without row");
    a_rd_pulse: assert property (rd_valid_o |=> !rd_valid_o)
        else $error("read pulse too long");

    c_take: cover property (take);
    c_read: cover property (rd_valid_o);
    c_refresh: cover property ($fell(pins_o.ras_n) && !$past(take));
endmodule : drc_ctrl_checker

bind drc_ctrl drc_ctrl_checker #(.REF_INTERVAL(REF_INTERVAL)) i_drc_ctrl_checker (.*);

/* File: tb/test_dram_16k_x1_strobe_interface.sv */
`timescale 1ns/10ps
// Random reads and writes checked against a reference array
module test_dram_16k_x1_strobe_interface;
    import drc_pkg::*;
    localparam int RI = 300;                        // Shortened refresh spacing
    localparam int WATCHDOG_CYC = 95000;            // Well above the expected run
    logic      ref_clk_i = 0, rst_i = 1, req_valid_i = 0, dout_i;
    drc_req_t  req_i = '0;
    logic      req_ready_o, rd_valid_o, rd_data_o, init_done_o;
    drc_pins_t pins_o;
    logic      ref_mem [2**ADDR_W] = '{default: 1'b0}; // Expected contents
    int        num_errors = 0, checks_done = 0;
    logic [ADDR_W-1:0] a;
    logic      d;

    drc_ctrl #(.REF_INTERVAL(RI)) i_drc_ctrl (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .req_valid_i (req_valid_i),
        .req_i       (req_i),
        .req_ready_o (req_ready_o),
        .rd_valid_o  (rd_valid_o),
        .rd_data_o   (rd_data_o),
        .init_done_o (init_done_o),
        .pins_o      (pins_o),
        .dout_i      (dout_i)
    );
    drc_dram_model i_drc_dram_model (.pins_i(pins_o), .dout_o(dout_i));

    // Clock generation
    initial
        forever #2 ref_clk_i = ~ref_clk_i;

    // Compare one bit against its expectation
    task automatic chk(input logic got, input logic exp, input string msg);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk

    // One request: wait for ready, then for a read wait for the read pulse
    task automatic op(input logic wr, input logic [ADDR_W-1:0] ad, input logic dv);
        int n = 0;
        req_valid_i = 1;
        req_i = '{wr: wr, addr: ad, din: dv};
        // Let the ready decode see the new request before it is looked at
        #0;
        while (req_ready_o !== 1'b1 && n++ < 4000)
            @(posedge ref_clk_i) #1;
        @(posedge ref_clk_i) #1 req_valid_i = 0;
        if (wr)
            ref_mem[ad] = dv;
        while (!wr && rd_valid_o !== 1'b1 && n++ < 4000)
            @(posedge ref_clk_i) #1;
        chk(n < 4000, 1'b1, "no answer");
        if (!wr)
            chk(rd_data_o, ref_mem[ad], "read data");
        // One edge between requests so valid never moves twice in a step
        @(posedge ref_clk_i) #1;
    endtask : op

    // Verdict and end of run
    task automatic final_report;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    // Main sequence
    initial
    begin
        void'($urandom(32'h562f_cec9));
        repeat (20) @(posedge ref_clk_i);
        #1 rst_i = 0;
        op(0, 14'h0000, 1'b0);
        chk(i_drc_dram_model.falls >= INIT_CYCLES, 1'b1, "wake-up cycles");
        chk(init_done_o, 1'b1, "init done");
        repeat (25)
        begin
            a = ADDR_W'($urandom);
            d = 1'($urandom);
            op(1, a, d);
            op(1, a ^ 14'h0080, ~d);
            op(0, a, 1'b0);
            op(0, a ^ 14'h0080, 1'b0);
            op(0, ADDR_W'($urandom), 1'b0);
        end
        repeat (ROWS * RI + 500) @(posedge ref_clk_i);
        for (int r = 0; r < ROWS; r++)
            chk($time - i_drc_dram_model.seen[r] <= (ROWS + 2) * RI * 4, 1'b1, "row stale");
        final_report();
    end

    // Watchdog against a hang
    initial
    begin
        #(WATCHDOG_CYC * 4);
        num_errors++;
        final_report();
    end
endmodule : test_dram_16k_x1_strobe_interface
